// ==== dv/crd_dma_model.sv ====
/* dma channel model: apb master for register access and fifo window reads
 * paced by the level request. assumes one apb slave on pclk. */
`timescale 1ns/1ps
`include "crd_defs.svh"
module crd_dma_model (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	input  wire logic        dma_req
);
	logic [31:0] got [0:7];
	logic        err_q;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// ============================================================
	// apb transfer, held until pready
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	// ============================================================
	// linked word and byte descriptors; a word request moves one chunk, or the words left if fewer,
	// a byte request one byte; each call is a freshly chosen idle channel
	task run(input int nw, input int nb, input int ch);
		int          i, k, d, n, wid;
		int          cnt [2];
		int          nxt [2];
		logic [31:0] q;
		i      = 0;
		wid    = 0;
		cnt[0] = nw;
		cnt[1] = nb;
		nxt[0] = (nb != 0) ? 1 : -1;
		nxt[1] = -1;
		d      = (nw > 0) ? 0 : 1;
		while (d >= 0) begin
			wid = (d == 0) ? 4 : 1;
			n   = 0;
			while (n < cnt[d]) begin
				@(posedge pclk);
				if (dma_req === 1'b1) begin
					k = (wid == 1) ? 1
					    : (cnt[d] - n < ch) ? cnt[d] - n : ch;
					repeat (k) begin
						xfer(1'b0, `CRD_OFS_FIFO, 32'h0, q);
						got[i] = q;
						i++;
						n++;
					end
					// one layer: no prefetch, let the request follow the pops
					repeat (2) @(posedge pclk);
				end
			end
			d = nxt[d];
		end
	endtask : run
endmodule : crd_dma_model

// ==== dv/tb_card_read_dma_path.sv ====
/* self-checking bench of the card read path: block reads with and without rounding, chunks of 1 and 2 words.
 * assumes crd_dma_model as apb master and dma channel. */
`timescale 1ns/1ps
`include "crd_defs.svh"
module tb_card_read_dma_path;
	logic              pclk, presetn, psel, penable, pwrite, pready;
	logic              pslverr, rx_ready, cmd_ready, card_busy, dma_req;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata, q;
	crd_pkg::crd_rx_t  rx;
	int                errors, n_checks;
	crd_read_dma uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .rx(rx),
		.rx_ready(rx_ready), .cmd_ready(cmd_ready), .card_busy(card_busy),
		.dma_req(dma_req));
	crd_dma_model dma (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .dma_req(dma_req));
	always #5 pclk = ~pclk;
	// ============================================================
	// helpers
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		dma.xfer(1'b1, a, d, q);
	endtask : wr
	function logic [7:0] bv(input int k);
		return 8'ha5 ^ k[7:0];
	endfunction : bv
	function logic [31:0] ew(input int i, input int len);
		int j;
		ew = 32'h0;
		for (j = 0; j < 4; j++)
			if (4 * i + j < len) ew[8 * j +: 8] = bv(4 * i + j);
	endfunction : ew
	task send(input int f, input int n);
		int k;
		for (k = f; k < n; k++) begin
			rx <= {1'b1, bv(k)};
			do @(posedge pclk); while (rx_ready !== 1'b1);
		end
		rx <= '0;
	endtask : send
	// ============================================================
	// one block read with dma handshake
	task blk(input int len, input logic rnd, input logic [1:0] cs);
		int nw, nb, i;
		nw = rnd ? (len + 3) / 4 : len / 4;
		nb = rnd ? 0 : len % 4;
		wr(`CRD_OFS_MODE, {15'h0, 1'b1, len[15:0]});
		wr(`CRD_OFS_DMACFG, 32'h0);
		wr(`CRD_OFS_DMACFG, {19'h0, rnd, 3'h0, 1'b1, 2'h0, cs, 4'h0});
		wr(`CRD_OFS_CTRL, 32'h1);
		fork
			send(0, len);
			dma.run(nw, nb, 1 << cs);
		join
		for (i = 0; i < nw + nb; i++)
			if (i < nw)
				chk("word", ew(i, len), dma.got[i]);
			else
				chk("byte", {24'h0, bv(i + 3 * nw)}, {24'h0, dma.got[i][7:0]});
		dma.xfer(1'b0, `CRD_OFS_STATUS, 32'h0, q);
		chk("done", 32'h1, {31'h0, q[2]});
		chk("count", 32'h0, {28'h0, q[11:8]});
		dma.xfer(1'b0, `CRD_OFS_STATUS, 32'h0, q);
		chk("done clear", 32'h0, {31'h0, q[2]});
		chk("rx idle", 32'h0, {31'h0, rx_ready});
		$display("test block %0d round %0d done", len, rnd);
	endtask : blk
	// ============================================================
	// main sequence
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		rx = '0;
		cmd_ready = 1'b1;
		card_busy = 1'b1;
		errors = 0;
		n_checks = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		dma.xfer(1'b0, `CRD_OFS_STATUS, 32'h0, q);
		chk("status busy", 32'h1, {30'h0, q[1:0]});
		card_busy <= 1'b0;
		dma.xfer(1'b0, `CRD_OFS_STATUS, 32'h0, q);
		chk("status ready", 32'h3, {30'h0, q[1:0]});
		dma.xfer(1'b0, 8'h20, 32'h0, q);
		chk("unmapped", 32'h1, {31'h0, dma.err_q});
		$display("test status done");
		wr(`CRD_OFS_MODE, 32'h0001_0004);
		wr(`CRD_OFS_CTRL, 32'h1);
		send(0, 4);
		repeat (4) @(posedge pclk);
		chk("req gated", 32'h0, {31'h0, dma_req});
		wr(`CRD_OFS_DMACFG, 32'h100);
		repeat (3) @(posedge pclk);
		chk("req", 32'h1, {31'h0, dma_req});
		dma.run(1, 0, 1);
		chk("word", ew(0, 4), dma.got[0]);
		$display("test gate done");
		wr(`CRD_OFS_DMACFG, 32'h0);
		wr(`CRD_OFS_MODE, 32'h0001_0020);
		wr(`CRD_OFS_CTRL, 32'h1);
		send(0, 28);
		repeat (3) @(posedge pclk);
		chk("stall", 32'h0, {31'h0, rx_ready});
		wr(`CRD_OFS_DMACFG, 32'h100);
		fork
			send(28, 32);
			dma.run(8, 0, 1);
		join
		for (int i = 0; i < 8; i++)
			chk("stall word", ew(i, 32), dma.got[i]);
		$display("test stall done");
		blk(8, 1'b0, 2'h1);
		blk(7, 1'b0, 2'h0);
		blk(6, 1'b1, 2'h0);
		blk(3, 1'b0, 2'h0);
		test_done();
	end
	initial begin
		#200000;
		errors++;
		test_done();
	end
endmodule : tb_card_read_dma_path

// ==== hw/crd_defs.svh ====
/*
 * Offsets, field positions, reset values and sizes of the card read path.
 * Assumes inclusion by bare name from the package and the design module.
 */
`ifndef CRD_DEFS_SVH
`define CRD_DEFS_SVH

// ============================================================
// register byte offsets
`define CRD_OFS_MODE      8'h00
`define CRD_OFS_DMACFG    8'h04
`define CRD_OFS_CTRL      8'h08
`define CRD_OFS_STATUS    8'h0c
`define CRD_OFS_FIFO      8'h10

// ============================================================
// field positions
`define CRD_MODE_LEN_MSB  15
`define CRD_MODE_STALL    16
`define CRD_CFG_OFS_MSB   1
`define CRD_CFG_CHK_LSB   4
`define CRD_CFG_HSEN      8
`define CRD_CFG_ROUND     12
`define CRD_CTRL_START    0
`define CRD_ST_COMMAND_READY_FLAG     0
`define CRD_ST_CARD_NOT_BUSY_FLAG    1
`define CRD_ST_DONE       2
`define CRD_ST_OVR        3
`define CRD_ST_CNT_LSB    8

// ============================================================
// reset values and sizes
`define CRD_MODE_RST      32'h0000_0000
`define CRD_CFG_RST       32'h0000_0000
`define CRD_FIFO_DEPTH    8
`define CRD_FIFO_AW       3

`endif

// ==== hw/crd_pkg.sv ====
/*
 * Types of the card read path.
 * Assumes crd_defs.svh is on the include path.
 */
`include "crd_defs.svh"

package crd_pkg;

	// ============================================================
	// received byte from the card link logic
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} crd_rx_t;

	// ============================================================
	// snapshot of what a read of the fifo window consumes
	typedef enum logic [1:0] {
		CRD_POP_NONE = 2'b00,
		CRD_POP_WORD = 2'b01,
		CRD_POP_BYTE = 2'b10
	} crd_pop_t;

endpackage : crd_pkg

// ==== hw/crd_read_dma.sv ====
/*
 * Single-block read data path of a card host: byte packer, receive fifo,
 * dma request handshake and apb register slave.
 * Assumes card link logic and command logic on pclk; the dma controller
 * reads the fifo window over apb, one word or one tail byte per read.
 */
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`include "crd_defs.svh"

module crd_read_dma (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output logic                 pready,
	output logic [31:0]          prdata,
	output logic                 pslverr,
	input  wire crd_pkg::crd_rx_t rx,
	output logic                 rx_ready,
	input  wire logic            cmd_ready,
	input  wire logic            card_busy,
	output logic                 dma_req
);

	// ============================================================
	// state
	logic [31:0]         mode_q, mode_d, cfg_q, cfg_d;
	logic [31:0]         mem_q [`CRD_FIFO_DEPTH];
	logic [31:0]         mem_d [`CRD_FIFO_DEPTH];
	logic [`CRD_FIFO_AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [`CRD_FIFO_AW:0]   cnt_q, cnt_d;
	logic [31:0]         pack_q, pack_d, tail_q, tail_d;
	logic [1:0]          pcnt_q, pcnt_d, tn_q, tn_d;
	logic [15:0]         rem_q, rem_d;
	logic                act_q, act_d, done_q, done_d, ovr_q, ovr_d;
	logic                pready_q, pready_d, slverr_q, slverr_d;
	logic                req_q, req_d, rdy_q, rdy_d;
	logic [31:0]         rd_q, rd_d;
	crd_pkg::crd_pop_t   pop_q, pop_d;

	logic                acc, wr, take, last, push;
	logic [31:0]         word;
	logic [`CRD_FIFO_AW:0]   chunk;

	// chunk size select codes 1, 2, 4 or 8 words
	function automatic logic [`CRD_FIFO_AW:0] chunk_words(
		input logic [1:0] sel);
		chunk_words = (`CRD_FIFO_AW+1)'(1) << sel;
	endfunction : chunk_words

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction : hit

	assign acc   = psel & penable & pready_q;
	assign wr    = acc & pwrite;
	assign take  = rx.valid & rdy_q & act_q & (rem_q != 16'h0000);
	assign last  = take & (rem_q == 16'h0001);
	assign chunk = chunk_words(cfg_q[`CRD_CFG_CHK_LSB+1:`CRD_CFG_CHK_LSB]);

	// ============================================================
	// next state
	always_comb begin
		mode_d   = mode_q;
		cfg_d    = cfg_q;
		mem_d    = mem_q;
		wp_d     = wp_q;
		rp_d     = rp_q;
		cnt_d    = cnt_q;
		pack_d   = pack_q;
		pcnt_d   = pcnt_q;
		tail_d   = tail_q;
		tn_d     = tn_q;
		rem_d    = rem_q;
		act_d    = act_q;
		done_d   = done_q;
		ovr_d    = ovr_q;
		pop_d    = pop_q;
		rd_d     = rd_q;
		slverr_d = slverr_q;
		push     = 1'b0;
		word     = pack_q;
		// apb: answer prepared in setup, acted upon in access
		pready_d = psel & ~penable;
		if (psel & ~penable) begin
			pop_d    = crd_pkg::CRD_POP_NONE;
			rd_d     = 32'h0000_0000;
			slverr_d = 1'b0;
			if (hit(paddr, `CRD_OFS_MODE))
				rd_d = mode_q;
			else if (hit(paddr, `CRD_OFS_DMACFG))
				rd_d = cfg_q;
			else if (hit(paddr, `CRD_OFS_STATUS)) begin
				rd_d[`CRD_ST_COMMAND_READY_FLAG]  = cmd_ready;
				rd_d[`CRD_ST_CARD_NOT_BUSY_FLAG] = ~card_busy;
				rd_d[`CRD_ST_DONE]    = done_q;
				rd_d[`CRD_ST_OVR]     = ovr_q;
				rd_d[`CRD_ST_CNT_LSB+`CRD_FIFO_AW:`CRD_ST_CNT_LSB] = cnt_q;
			end else if (hit(paddr, `CRD_OFS_FIFO) & ~pwrite) begin
				if (cnt_q != '0) begin
					rd_d  = mem_q[rp_q];
					pop_d = crd_pkg::CRD_POP_WORD;
				end else if (tn_q != 2'b00) begin
					rd_d  = {24'h000000, tail_q[7:0]};
					pop_d = crd_pkg::CRD_POP_BYTE;
				end
			end else if (!hit(paddr, `CRD_OFS_CTRL))
				slverr_d = 1'b1;
		end
		if (wr & hit(paddr, `CRD_OFS_MODE))
			mode_d = pwdata;
		if (wr & hit(paddr, `CRD_OFS_DMACFG))
			cfg_d = pwdata;
		// reading status clears only what the read showed; a new set wins
		if (acc & ~pwrite & hit(paddr, `CRD_OFS_STATUS)) begin
			if (rd_q[`CRD_ST_DONE])
				done_d = 1'b0;
			if (rd_q[`CRD_ST_OVR])
				ovr_d = 1'b0;
		end
		// dma reads of the window
		if (acc & (pop_q == crd_pkg::CRD_POP_WORD)) begin
			rp_d  = rp_q + 1'b1;
			cnt_d = cnt_d - 1'b1;
		end
		if (acc & (pop_q == crd_pkg::CRD_POP_BYTE)) begin
			tail_d = {8'h00, tail_q[31:8]};
			tn_d   = tn_q - 2'b01;
		end
		// start of a block read
		if (wr & hit(paddr, `CRD_OFS_CTRL) & pwdata[`CRD_CTRL_START]) begin
			rem_d  = mode_q[`CRD_MODE_LEN_MSB:0];
			act_d  = 1'b1;
			done_d = 1'b0;
			pack_d = 32'h0000_0000;
			pcnt_d = 2'b00;
			tn_d   = 2'b00;
		end
		// byte packer
		if (take) begin
			word = pack_q;
			word[8*pcnt_q +: 8] = rx.data;
			rem_d  = rem_q - 16'h0001;
			pcnt_d = pcnt_q + 2'b01;
			pack_d = word;
			if (pcnt_q == 2'b11) begin
				push   = 1'b1;
				pack_d = 32'h0000_0000;
			end else if (last) begin
				pack_d = 32'h0000_0000;
				pcnt_d = 2'b00;
				if (cfg_q[`CRD_CFG_ROUND])
					push = 1'b1;
				else begin
					tail_d = word;
					tn_d   = pcnt_q + 2'b01;
				end
			end
		end
		if (push) begin
			if (cnt_q == `CRD_FIFO_DEPTH) begin
				ovr_d = 1'b1;
			end else begin
				mem_d[wp_q] = word;
				wp_d        = wp_q + 1'b1;
				cnt_d       = cnt_d + 1'b1;
			end
		end
		// done once every byte arrived and the dma drained all of them
		if (act_q & (rem_q == 16'h0000) & (cnt_q == '0) & (tn_q == 2'b00)
		    & ~push) begin
			act_d  = 1'b0;
			done_d = 1'b1;
		end
		// stall reception one word short of full
		rdy_d = act_d & ((cnt_d < (`CRD_FIFO_AW+1)'(`CRD_FIFO_DEPTH - 1))
		        | ~mode_q[`CRD_MODE_STALL]);
		// request: a whole chunk, or the remains after the last byte
		req_d = cfg_q[`CRD_CFG_HSEN]
		        & ((cnt_q >= chunk)
		        | ((rem_q == 16'h0000) & ((cnt_q != '0)
		        | (tn_q != 2'b00))));
	end

	// ============================================================
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q   <= `CRD_MODE_RST;
			cfg_q    <= `CRD_CFG_RST;
			for (int i = 0; i < `CRD_FIFO_DEPTH; i++)
				mem_q[i] <= 32'h0000_0000;
			wp_q     <= '0;
			rp_q     <= '0;
			cnt_q    <= '0;
			pack_q   <= 32'h0000_0000;
			pcnt_q   <= 2'b00;
			tail_q   <= 32'h0000_0000;
			tn_q     <= 2'b00;
			rem_q    <= 16'h0000;
			act_q    <= 1'b0;
			done_q   <= 1'b0;
			ovr_q    <= 1'b0;
			pop_q    <= crd_pkg::CRD_POP_NONE;
			rd_q     <= 32'h0000_0000;
			pready_q <= 1'b0;
			slverr_q <= 1'b0;
			req_q    <= 1'b0;
			rdy_q    <= 1'b0;
		end else begin
			mode_q   <= mode_d;
			cfg_q    <= cfg_d;
			mem_q    <= mem_d;
			wp_q     <= wp_d;
			rp_q     <= rp_d;
			cnt_q    <= cnt_d;
			pack_q   <= pack_d;
			pcnt_q   <= pcnt_d;
			tail_q   <= tail_d;
			tn_q     <= tn_d;
			rem_q    <= rem_d;
			act_q    <= act_d;
			done_q   <= done_d;
			ovr_q    <= ovr_d;
			pop_q    <= pop_d;
			rd_q     <= rd_d;
			pready_q <= pready_d;
			slverr_q <= slverr_d;
			req_q    <= req_d;
			rdy_q    <= rdy_d;
		end
	end

	assign pready   = pready_q;
	assign prdata   = rd_q;
	assign pslverr  = slverr_q;
	assign rx_ready = rdy_q;
	assign dma_req  = req_q;

	// ============================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel & ~penable;
	endsequence
	sequence s_ack;
		pready_q ##1 !pready_q;
	endsequence

	AST_APB_ACK: assert property (s_setup |=> s_ack)
		else $error("apb answer not one cycle after setup");
	AST_REQ_OFF: assert property (!cfg_q[`CRD_CFG_HSEN] |=> !req_q)
		else $error("request while handshake disabled");
	AST_REQ_CHUNK: assert property
		(cfg_q[`CRD_CFG_HSEN] && cnt_q >= chunk |=> req_q)
		else $error("chunk in fifo without request");
	AST_REQ_CAUSE: assert property
		(req_q |-> $past(cnt_q) >= $past(chunk)
		 || $past(rem_q) == 16'h0000)
		else $error("request without a chunk or final remains");
	AST_STALL: assert property
		(mode_q[`CRD_MODE_STALL] && !act_d |=> !rdy_q)
		else $error("ready while idle");
	AST_NO_OVR: assert property
		(mode_q[`CRD_MODE_STALL] && act_q
		 |-> !(push && cnt_q == `CRD_FIFO_DEPTH))
		else $error("fifo overflow with stall enabled");
	AST_PAD: assert property
		(last && cfg_q[`CRD_CFG_ROUND] |=> tn_q == 2'b00 && pcnt_q == 2'b00)
		else $error("rounded block left a tail");
	AST_DONE_CAUSE: assert property
		($rose(done_q) |-> $past(cnt_q) == '0 && $past(tn_q) == 2'b00
		 && $past(rem_q) == 16'h0000)
		else $error("done before fifo drained");
	AST_DONE_HOLD: assert property
		(done_q && !acc && !wr |=> done_q)
		else $error("done dropped without a clear");
	AST_POP: assert property
		(acc && pop_q == crd_pkg::CRD_POP_WORD && !push |=>
		 cnt_q == $past(cnt_q) - 1'b1)
		else $error("word read did not pop");

endmodule : crd_read_dma
